// *** rtl/fsi_regs.sv ***
// Status and interrupt register bank of the flash controller.
// Assumes operation events from the sequencer are one-cycle pulses
// synchronous to clk_sys, and an APB master on the register side.
//
// Summary of operation
// - Busy plus operation flag while running, busy alone for verify
// - Success clears all but OTP lock and suspend bits
// - Failed load leaves uncorrectable ECC code
// - Reset-aborted load reports no-error ECC code
// - Cold and warm resets give distinct defaults
// - Master, load, program flags at bits 15,7,6
// - Interrupt pin driven from master flag
// - Cleared master drives pin per polarity
// - Any done flag sets master flag
// - Listed misc commands set master flag
// - Load completion sets load flag
// - Program completion sets program flag
// - Written zero clears flags, reset loads its default flags
// - Erase completion sets erase flag, bit 5
// - Reset completion sets reset flag, bit 4
// - Polarity selects pin sense
// - Pins undriven until buffer enable set
`timescale 1ns/100ps
`default_nettype none

module fsi_regs
  import fsi_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequencer events
  input wire logic warm_reset,
  input wire logic op_start,
  input wire logic [2:0] op_kind,
  input wire logic op_done,
  input wire logic op_fail,
  input wire logic op_lock_fail,
  input wire logic op_aborted,
  input wire logic invalid_cmd,
  input wire logic erase_suspend,
  input wire logic erase_resume,
  input wire logic otp_locked,
  input wire logic [1:0] ecc_main_in,
  input wire logic [1:0] ecc_spare_in,
  // Command completion
  input wire logic cmd_done,
  input wire logic [15:0] cmd_code,
  input wire logic buffer_load_done,
  input wire logic boot_done,
  // Pins
  output logic irq_pin,
  output logic irq_pin_oe,
  output logic ready_pin,
  output logic ready_pin_oe
);

  typedef struct packed {
    logic [15:0] outcome;
    logic [15:0] irq;
    logic pol;
    logic obe;
    logic [1:0] main_ecc_result;
    logic [1:0] spare_ecc_result;
    logic suspended;
    fsi_op_e op;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq_pin;
    logic irq_pin_oe;
    logic ready_pin;
    logic ready_pin_oe;
  } fsi_state_s;

  fsi_state_s st;
  fsi_state_s next_st;

  function automatic fsi_class_e cmd_class(input logic [15:0] c);
    unique case (c)
      CMD_LOAD0, CMD_LOAD1: cmd_class = FSI_CL_LOAD;
      CMD_PROG0, CMD_PROG1, CMD_PROG2: cmd_class = FSI_CL_PROG;
      CMD_ERASE0, CMD_ERASE1, CMD_ERASE2: cmd_class = FSI_CL_ERASE;
      CMD_RST0, CMD_RST1, CMD_RST2: cmd_class = FSI_CL_RESET;
      CMD_MISC0, CMD_MISC1, CMD_MISC2, CMD_MISC3, CMD_MISC4:
        cmd_class = FSI_CL_MISC;
      default: cmd_class = FSI_CL_NONE;
    endcase
  endfunction

  function automatic logic [15:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[17:2];
  endfunction

  // Flag bit of the running operation
  function automatic logic [15:0] op_flag(input fsi_op_e k);
    logic [15:0] f;
    f = 16'h0000;
    unique case (k)
      FSI_OP_LOAD: f[ST_LOAD] = 1'b1;
      FSI_OP_PROG: f[ST_PROG] = 1'b1;
      FSI_OP_ERASE, FSI_OP_MERASE: f[ST_ERASE] = 1'b1;
      FSI_OP_RESET: f[ST_RESET_BUSY] = 1'b1;
      FSI_OP_VERIFY: f = 16'h0000;
      // Kinds 6 and 7 are not operations
      default: f = 16'h0000;
    endcase
    op_flag = f;
  endfunction

  logic [15:0] susp_bits;
  logic [15:0] irq_set;
  logic [15:0] irq_keep;
  fsi_class_e cls;
  logic wr_acc;
  logic setup;
  logic hit;

  always_comb begin
    next_st = st;
    susp_bits = 16'h0000;
    susp_bits[ST_ERASE] = st.suspended;
    susp_bits[ST_SUSP] = st.suspended;
    cls = cmd_done ? cmd_class(cmd_code) : FSI_CL_NONE;
    setup = psel && !penable;
    wr_acc = psel && penable && pwrite && st.pready;

    // Operation outcome word
    if (op_start) begin
      next_st.op = fsi_op_e'(op_kind);
      next_st.outcome = susp_bits | op_flag(fsi_op_e'(op_kind));
      next_st.outcome[ST_BUSY] = 1'b1;
    end else if (op_done && !op_fail) begin
      // Program or load inside a suspension returns to suspended view
      next_st.outcome = susp_bits;
    end else if (op_done) begin
      next_st.outcome = susp_bits | op_flag(st.op);
      if (st.op == FSI_OP_VERIFY || st.op == FSI_OP_MERASE) begin
        next_st.outcome[ST_ERASE] = 1'b1;
      end
      next_st.outcome[ST_RESET_BUSY] = op_aborted;
      next_st.outcome[ST_LOCK] = op_lock_fail;
      next_st.outcome[ST_ERROR] = 1'b1;
    end else if (invalid_cmd) begin
      next_st.outcome = susp_bits;
      next_st.outcome[ST_ERROR] = 1'b1;
    end else if (erase_suspend) begin
      next_st.suspended = 1'b1;
      next_st.outcome = 16'h0000;
      next_st.outcome[ST_ERASE] = 1'b1;
      next_st.outcome[ST_SUSP] = 1'b1;
    end else if (erase_resume) begin
      // A load or program inside the suspension replaced the kind
      next_st.op = FSI_OP_ERASE;
      next_st.suspended = 1'b0;
      next_st.outcome = 16'h0000;
      next_st.outcome[ST_ERASE] = 1'b1;
      next_st.outcome[ST_BUSY] = 1'b1;
    end
    if (op_done && (st.op == FSI_OP_ERASE || st.op == FSI_OP_MERASE)) begin
      next_st.suspended = 1'b0;
    end
    next_st.outcome[ST_OTP_LOCKED_FLAG] = otp_locked;
    next_st.outcome[ST_TIMEOUT] = 1'b0;

    // ECC summary of the last load
    if (op_done && st.op == FSI_OP_LOAD) begin
      if (op_aborted) begin
        next_st.main_ecc_result = ECC_NONE;
        next_st.spare_ecc_result = ECC_NONE;
      end else if (op_fail && ecc_spare_in != ECC_UNCORR) begin
        next_st.main_ecc_result = ECC_UNCORR;
        next_st.spare_ecc_result = ecc_spare_in;
      end else begin
        next_st.main_ecc_result = ecc_main_in;
        next_st.spare_ecc_result = ecc_spare_in;
      end
    end

    // Interrupt flags: writes of zero clear, sets win over clears
    irq_keep = 16'hFFFF;
    if (wr_acc && reg_index(paddr) == IDX_IRQ_FLAGS) begin
      irq_keep = pwdata[15:0];
    end
    irq_set = 16'h0000;
    irq_set[IRQ_LOAD] = cls == FSI_CL_LOAD || buffer_load_done
      || boot_done;
    irq_set[IRQ_PROG] = cls == FSI_CL_PROG;
    irq_set[IRQ_ERASE] = cls == FSI_CL_ERASE;
    irq_set[IRQ_RESET] = cls == FSI_CL_RESET;
    irq_set[IRQ_MASTER] = |irq_set[IRQ_LOAD:IRQ_RESET]
      || cls == FSI_CL_MISC;
    next_st.irq = (st.irq & irq_keep) | irq_set;
    next_st.irq[14:8] = 7'h00;
    next_st.irq[3:0] = 4'h0;
    if (warm_reset) begin
      next_st.irq = IRQ_WARM_RST;
    end

    // Pin configuration
    if (wr_acc && reg_index(paddr) == IDX_PIN_CFG) begin
      next_st.pol = pwdata[CFG_POL];
      next_st.obe = pwdata[CFG_OBE];
    end

    // Pins follow the next register value so they stay flop outputs
    next_st.irq_pin = next_st.pol ? next_st.irq[IRQ_MASTER]
      : !next_st.irq[IRQ_MASTER];
    next_st.irq_pin_oe = next_st.obe;
    next_st.ready_pin = !next_st.outcome[ST_BUSY];
    next_st.ready_pin_oe = next_st.obe;

    // APB: decode in setup, answer in the first access cycle
    hit = 1'b1;
    next_st.prdata = 32'h0000_0000;
    unique case (reg_index(paddr))
      IDX_OUTCOME: next_st.prdata[15:0] = st.outcome;
      IDX_IRQ_FLAGS: next_st.prdata[15:0] = st.irq;
      IDX_PIN_CFG: begin
        next_st.prdata[CFG_POL] = st.pol;
        next_st.prdata[CFG_OBE] = st.obe;
      end
      IDX_ECC: next_st.prdata[3:0] = {st.main_ecc_result,
        st.spare_ecc_result};
      default: hit = 1'b0;
    endcase
    if (!setup || pwrite) begin
      next_st.prdata = 32'h0000_0000;
    end
    next_st.pready = setup;
    next_st.pslverr = setup && (!hit || (pwrite
      && reg_index(paddr) == IDX_OUTCOME));
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.irq <= IRQ_COLD_RST;
      st.pol <= IRQ_POL_RST;
      st.obe <= OBE_RST;
      st.op <= FSI_OP_LOAD;
      st.irq_pin <= 1'b1;
      st.ready_pin <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq_pin = st.irq_pin;
  assign irq_pin_oe = st.irq_pin_oe;
  assign ready_pin = st.ready_pin;
  assign ready_pin_oe = st.ready_pin_oe;

  chk_start_busy_flag: assert property (@(posedge clk_sys)
    disable iff (rst) op_start && op_kind == 3'b000
      |=> st.outcome[ST_BUSY] && st.outcome[ST_LOAD])
    else $error("load start did not show busy and load");

  chk_ok_clears_word: assert property (@(posedge clk_sys)
    disable iff (rst) op_done && !op_fail && !op_start && !st.suspended
      |=> st.outcome[15:7] == 9'h000)
    else $error("successful operation left status bits set");

  chk_fail_sets_error: assert property (@(posedge clk_sys)
    disable iff (rst) op_done && op_fail && !op_start
      |=> st.outcome[ST_ERROR] && !st.outcome[ST_BUSY])
    else $error("failure did not set error");

  chk_suspend_bits: assert property (@(posedge clk_sys)
    disable iff (rst) erase_suspend && !op_start && !op_done && !invalid_cmd
      |=> st.outcome[ST_SUSP] && st.outcome[ST_ERASE])
    else $error("suspend not reported");

  chk_load_fail_ecc: assert property (@(posedge clk_sys)
    disable iff (rst) op_done && op_fail && !op_aborted
      && st.op == FSI_OP_LOAD
      |=> st.main_ecc_result == ECC_UNCORR
        || st.spare_ecc_result == ECC_UNCORR)
    else $error("failed load lacks uncorrectable code");

  chk_abort_ecc_zero: assert property (@(posedge clk_sys)
    disable iff (rst) op_done && op_aborted && st.op == FSI_OP_LOAD
      |=> {st.main_ecc_result, st.spare_ecc_result} == 4'h0)
    else $error("aborted load ECC not cleared");

  chk_warm_defaults: assert property (@(posedge clk_sys)
    disable iff (rst) warm_reset |=> st.irq == IRQ_WARM_RST)
    else $error("warm reset value wrong");

  chk_pin_polarity: assert property (@(posedge clk_sys)
    disable iff (rst) st.irq_pin == (st.pol ? st.irq[IRQ_MASTER]
      : !st.irq[IRQ_MASTER]))
    else $error("interrupt pin disagrees with master flag");

  chk_done_sets_master: assert property (@(posedge clk_sys)
    disable iff (rst)
    cmd_done && cmd_class(cmd_code) != FSI_CL_NONE && !warm_reset
      |=> st.irq[IRQ_MASTER] && st.irq_pin == st.pol)
    else $error("completion did not raise master flag");

  chk_prog_flag: assert property (@(posedge clk_sys)
    disable iff (rst) cmd_done && cmd_code == CMD_PROG1 && !warm_reset
      |=> st.irq[IRQ_PROG])
    else $error("program completion not flagged");

  chk_zero_clears: assert property (@(posedge clk_sys)
    disable iff (rst) psel && penable && pwrite && st.pready && !warm_reset
      && paddr[17:2] == IDX_IRQ_FLAGS && !pwdata[IRQ_LOAD]
      && !buffer_load_done && !boot_done && !cmd_done
      |=> !st.irq[IRQ_LOAD])
    else $error("written zero did not clear load flag");

  chk_pins_enabled: assert property (@(posedge clk_sys)
    disable iff (rst) !st.obe |-> !irq_pin_oe && !ready_pin_oe)
    else $error("pins driven without buffer enable");

  chk_apb_answer: assert property (@(posedge clk_sys) disable iff (rst)
    psel && !penable |=> pready)
    else $error("no answer in first access cycle");

endmodule // fsi_regs

`default_nettype wire

// *** shared/fsi_pkg.sv ***
// Package for the flash status and interrupt register bank.
// Assumes a 10 MHz system clock and an APB master with 32-bit data.
package fsi_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_OUTCOME = 16'hF240;
  localparam logic [15:0] IDX_IRQ_FLAGS = 16'hF241;
  localparam logic [15:0] IDX_PIN_CFG = 16'hF242;
  localparam logic [15:0] IDX_ECC = 16'hFF00;
  localparam int ADDR_W = 18;

  // Outcome status word fields
  localparam int ST_BUSY = 15;
  localparam int ST_LOCK = 14;
  localparam int ST_LOAD = 13;
  localparam int ST_PROG = 12;
  localparam int ST_ERASE = 11;
  localparam int ST_ERROR = 10;
  localparam int ST_SUSP = 9;
  localparam int ST_RESET_BUSY = 7;
  localparam int ST_OTP_LOCKED_FLAG = 6;
  localparam int ST_TIMEOUT = 0;

  // Interrupt flag fields and reset values
  localparam int IRQ_MASTER = 15;
  localparam int IRQ_LOAD = 7;
  localparam int IRQ_PROG = 6;
  localparam int IRQ_ERASE = 5;
  localparam int IRQ_RESET = 4;
  localparam logic [15:0] IRQ_COLD_RST = 16'h8080;
  localparam logic [15:0] IRQ_WARM_RST = 16'h8010;

  // Pin configuration fields and reset values
  localparam int CFG_POL = 0;
  localparam int CFG_OBE = 1;
  localparam logic IRQ_POL_RST = 1'b1;
  localparam logic OBE_RST = 1'b0;

  // ECC result codes
  localparam logic [1:0] ECC_NONE = 2'h0;
  localparam logic [1:0] ECC_UNCORR = 2'h2;

  // Command codes that raise interrupt flags
  localparam logic [15:0] CMD_LOAD0 = 16'h0000;
  localparam logic [15:0] CMD_LOAD1 = 16'h0013;
  localparam logic [15:0] CMD_PROG0 = 16'h0080;
  localparam logic [15:0] CMD_PROG1 = 16'h001A;
  localparam logic [15:0] CMD_PROG2 = 16'h001B;
  localparam logic [15:0] CMD_ERASE0 = 16'h0094;
  localparam logic [15:0] CMD_ERASE1 = 16'h0095;
  localparam logic [15:0] CMD_ERASE2 = 16'h0030;
  localparam logic [15:0] CMD_RST0 = 16'h00B0;
  localparam logic [15:0] CMD_RST1 = 16'h00F0;
  localparam logic [15:0] CMD_RST2 = 16'h00F3;
  localparam logic [15:0] CMD_MISC0 = 16'h0065;
  localparam logic [15:0] CMD_MISC1 = 16'h0023;
  localparam logic [15:0] CMD_MISC2 = 16'h0071;
  localparam logic [15:0] CMD_MISC3 = 16'h002A;
  localparam logic [15:0] CMD_MISC4 = 16'h002C;

  typedef enum logic [2:0] {
    FSI_OP_LOAD = 3'b000,
    FSI_OP_PROG = 3'b001,
    FSI_OP_ERASE = 3'b010,
    FSI_OP_RESET = 3'b011,
    FSI_OP_MERASE = 3'b100,
    FSI_OP_VERIFY = 3'b101
  } fsi_op_e;

  typedef enum logic [2:0] {
    FSI_CL_NONE = 3'b000,
    FSI_CL_LOAD = 3'b001,
    FSI_CL_PROG = 3'b010,
    FSI_CL_ERASE = 3'b011,
    FSI_CL_RESET = 3'b100,
    FSI_CL_MISC = 3'b101
  } fsi_class_e;

endpackage

// *** sim/fsi_host_model.sv ***
// APB host model for the flash status and interrupt bank.
// Assumes the bench calls xfer for one transfer at a time.
`timescale 1ns/100ps
`default_nettype none

module fsi_host_model
  import fsi_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end

  // No fixed latency assumed; the bench watchdog bounds a hang
  task automatic xfer(input logic wr, input logic [15:0] idx,
      input logic [15:0] wd, output logic [15:0] rd, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released bus shows junk so stale values cannot pass
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule // fsi_host_model

`default_nettype wire

// *** sim/fsi_regs_tb.sv ***
// Bench for the flash status and interrupt register bank.
// Assumes the APB host model and one-cycle sequencer events.
`timescale 1ns/100ps
`default_nettype none

module fsi_regs_tb
  import fsi_pkg::*;
  ;
  localparam logic [7:0] GO = 8'h01, FIN = 8'h02, BAD = 8'h04;
  localparam logic [7:0] SUS = 8'h08, RES = 8'h10, CMD = 8'h20;
  localparam logic [15:0] OTP = 16'h0040;
  logic clk_sys = 1'b0, rst = 1'b1, warm_reset = 1'b0, otp_locked = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, rerr;
  logic irq_pin, irq_pin_oe, ready_pin, ready_pin_oe;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] ev = 8'h00;
  logic [2:0] qual = 3'b000, op_kind = 3'd0;
  logic [1:0] ecc_spare = 2'b00;
  logic [15:0] cmd_code = 16'h0000, rdat;
  int fail_count = 0, tests_run = 0, cycles = 0;
  logic [15:0] busy_w [6] = '{16'hA000, 16'h9000, 16'h8800, 16'h8080,
    16'h8800, 16'h8000};
  // Kind, fail/lock/abort qualifiers, end status
  // Lock and abort only qualify a failure, so fail rides along
  logic [21:0] fails [11] = '{{3'd0, 3'b110, 16'h6400},
    {3'd0, 3'b100, 16'h2400}, {3'd0, 3'b101, 16'h2480},
    {3'd1, 3'b100, 16'h1400}, {3'd1, 3'b101, 16'h1480},
    {3'd1, 3'b110, 16'h5400}, {3'd2, 3'b100, 16'h0C00},
    {3'd2, 3'b101, 16'h0C80}, {3'd2, 3'b110, 16'h4C00},
    {3'd4, 3'b100, 16'h0C00}, {3'd5, 3'b100, 16'h0C00}};
  // Command code, expected flags
  logic [31:0] cmds [16] = '{32'h0000_8080, 32'h0013_8080, 32'h0080_8040,
    32'h001A_8040, 32'h001B_8040, 32'h0094_8020, 32'h0095_8020,
    32'h0030_8020, 32'h00B0_8010, 32'h00F0_8010, 32'h00F3_8010,
    32'h0065_8000, 32'h0023_8000, 32'h0071_8000, 32'h002A_8000,
    32'h002C_8000};

  always #50 clk_sys = ~clk_sys;

  fsi_regs i_fsi_regs (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .warm_reset(warm_reset),
    .op_start(ev[0]), .op_kind(op_kind), .op_done(ev[1]),
    .op_fail(qual[2]), .op_lock_fail(qual[1]), .op_aborted(qual[0]),
    .invalid_cmd(ev[2]), .erase_suspend(ev[3]), .erase_resume(ev[4]),
    .otp_locked(otp_locked), .ecc_main_in(2'b01), .ecc_spare_in(ecc_spare),
    .cmd_done(ev[5]), .cmd_code(cmd_code), .buffer_load_done(ev[6]),
    .boot_done(ev[7]), .irq_pin(irq_pin), .irq_pin_oe(irq_pin_oe),
    .ready_pin(ready_pin), .ready_pin_oe(ready_pin_oe)
  );

  fsi_host_model i_fsi_host_model (
    .clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
  );

  task automatic chk16(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
    i_fsi_host_model.xfer(1'b0, idx, 16'h0000, rdat, rerr);
    chk16($sformatf("reg %h", idx), exp, rdat);
    chk1("pslverr", 1'b0, rerr);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] d,
      input logic err);
    i_fsi_host_model.xfer(1'b1, idx, d, rdat, rerr);
    chk1("pslverr", err, rerr);
  endtask

  task automatic pulse(input logic [7:0] e, input logic [2:0] q);
    @(posedge clk_sys);
    ev <= e;
    qual <= q;
    @(posedge clk_sys);
    ev <= 8'h00;
    qual <= 3'b000;
  endtask

  task automatic run_op(input logic [2:0] k, input logic [2:0] q,
      input logic [15:0] busy, input logic [15:0] fin);
    op_kind <= k;
    pulse(GO, 3'b000);
    rd(IDX_OUTCOME, busy | OTP);
    chk1("ready_pin", ~busy[15], ready_pin);
    pulse(FIN, q);
    rd(IDX_OUTCOME, fin | OTP);
  endtask

  task automatic print_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(IDX_IRQ_FLAGS, 16'h8080);
    rd(IDX_OUTCOME, 16'h0000);
    chk1("irq_pin_oe", 1'b0, irq_pin_oe);
    chk1("ready_pin_oe", 1'b0, ready_pin_oe);
    wr(IDX_PIN_CFG, 16'h0003, 1'b0);
    rd(IDX_PIN_CFG, 16'h0003);
    chk1("irq_pin_oe", 1'b1, irq_pin_oe);
    chk1("ready_pin_oe", 1'b1, ready_pin_oe);
    chk1("irq_pin", 1'b1, irq_pin);
    wr(IDX_IRQ_FLAGS, 16'hFFFF, 1'b0);
    rd(IDX_IRQ_FLAGS, 16'h8080);
    wr(IDX_IRQ_FLAGS, 16'h0000, 1'b0);
    rd(IDX_IRQ_FLAGS, 16'h0000);
    chk1("irq_pin", 1'b0, irq_pin);
    wr(IDX_PIN_CFG, 16'h0002, 1'b0);
    rd(IDX_PIN_CFG, 16'h0002);
    chk1("irq_pin", 1'b1, irq_pin);
    foreach (cmds[i]) begin
      cmd_code <= cmds[i][31:16];
      pulse(CMD, 3'b000);
      rd(IDX_IRQ_FLAGS, cmds[i][15:0]);
      chk1("irq_pin", 1'b0, irq_pin);
      wr(IDX_IRQ_FLAGS, 16'h0000, 1'b0);
    end
    for (int i = 6; i < 8; i++) begin
      wr(IDX_IRQ_FLAGS, 16'h0000, 1'b0);
      pulse(8'h01 << i, 3'b000);
      rd(IDX_IRQ_FLAGS, 16'h8080);
    end
    warm_reset <= 1'b1;
    @(posedge clk_sys);
    warm_reset <= 1'b0;
    rd(IDX_IRQ_FLAGS, 16'h8010);
    rd(IDX_PIN_CFG, 16'h0002);
    i_fsi_host_model.xfer(1'b0, 16'h1234, 16'h0000, rdat, rerr);
    chk16("unmapped data", 16'h0000, rdat);
    chk1("unmapped pslverr", 1'b1, rerr);
    wr(IDX_OUTCOME, 16'hFFFF, 1'b1);
    otp_locked <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      run_op(3'(k), 3'b000, busy_w[k], 16'h0000);
    end
    foreach (fails[i]) begin
      run_op(fails[i][21:19], fails[i][18:16], busy_w[fails[i][21:19]],
        fails[i][15:0]);
      if (fails[i][21:16] == 6'b000_100) rd(IDX_ECC, 16'h0008);
      if (fails[i][21:16] == 6'b000_101) rd(IDX_ECC, 16'h0000);
    end
    // Spare already uncorrectable: main keeps its own result
    ecc_spare <= ECC_UNCORR;
    run_op(3'd0, 3'b100, 16'hA000, 16'h2400);
    rd(IDX_ECC, 16'h0006);
    ecc_spare <= ECC_NONE;
    pulse(BAD, 3'b000);
    rd(IDX_OUTCOME, 16'h0400 | OTP);
    op_kind <= 3'd2;
    pulse(GO, 3'b000);
    pulse(SUS, 3'b000);
    rd(IDX_OUTCOME, 16'h0A00 | OTP);
    run_op(3'd1, 3'b100, 16'h9A00, 16'h1E00);
    pulse(BAD, 3'b000);
    rd(IDX_OUTCOME, 16'h0E00 | OTP);
    run_op(3'd0, 3'b000, 16'hAA00, 16'h0A00);
    pulse(RES, 3'b000);
    pulse(FIN, 3'b000);
    rd(IDX_OUTCOME, OTP);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(IDX_IRQ_FLAGS, 16'h8080);
    rd(IDX_PIN_CFG, 16'h0001);
    chk1("irq_pin_oe", 1'b0, irq_pin_oe);
    print_verdict();
  end
endmodule // fsi_regs_tb

`default_nettype wire
